// >>> src/qawd_answer_eval.sv
`timescale 1ns/1ps
// Contract
// - Three good in window one plus one good in window two passes, new question, flags clear.
// - Fourth answer ends the cycle at once, without waiting for window end.
// - Any failing outcome increments failure counter and keeps the same question.
// - Window two expiring with under four answers ends cycle and sets timeout.
// - Under three in window one, four total, all good: only sequence error.
// - Under three in window one, four total, some bad: answer and sequence error.
// - Any bad answer sets answer error at cycle end, whichever window.
// - Exactly three good in window one, none later: only timeout.
// - One or two good in window one, none later: sequence error and timeout.
// - Flags update at cycle end; reading returns them and clears them.
// - Evaluation runs only while answer mode select is zero.
module qawd_answer_eval
  import qawd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wd_init,
  input wire logic first_response_window_active,
  input wire logic win2_active,
  input wire logic win2_expire,
  input wire logic [7:0] expected_answer,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [1:0] answer_counter,
  output logic cycle_end,
  output logic fail_inc,
  output logic fail_dec,
  output logic new_question,
  output logic answer_mode_select,
  output logic answer_error_flag,
  output logic early_answer_flag,
  output logic sequence_error_flag,
  output logic timeout_flag
);

  // ==========================================
  // Reset release
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ==========================================
  // Address decode
  // Shared by the clear logic and its check so both agree on what a result read is
  function automatic logic result_read(input logic rd, input logic [3:0] addr);
    return rd && addr == QAWD_ADDR_RESULT;
  endfunction

  // ==========================================
  // Answer intake and verdict
  logic [2:0] first_response_window_count;
  logic any_bad;
  logic mode_write;
  logic restart;
  logic ans_take;
  logic ans_ok;
  logic fourth;
  logic expire;
  logic end_now;
  logic pass;
  logic [2:0] next_first_response_window_count;
  logic next_any_bad;
  logic [3:0] next_flags;
  logic [3:0] flags;

  assign flags = {answer_error_flag, early_answer_flag, sequence_error_flag, timeout_flag};

  always_comb begin
    mode_write = reg_wr && reg_addr == QAWD_ADDR_CTRL;
    // A mode change is an initialisation event, just like wd_init
    restart = wd_init || (mode_write && reg_wdata[QAWD_CTRL_MODE] != answer_mode_select);
    // Answers outside both windows are dropped
    // evaluation only in multi-answer mode
    ans_take = reg_wr && reg_addr == QAWD_ADDR_ANSWER && !answer_mode_select
               && (first_response_window_active || win2_active) && !restart;
    ans_ok = reg_wdata == expected_answer;
    next_first_response_window_count = first_response_window_count + {2'h0, ans_take && first_response_window_active};
    next_any_bad = any_bad || (ans_take && !ans_ok);
    fourth = ans_take && answer_counter == QAWD_LAST_SLOT;
    // window expiry with fewer answers; a simultaneous fourth answer wins
    expire = win2_expire && !answer_mode_select && !fourth && !restart;
    end_now = fourth || expire;
    pass = fourth && next_first_response_window_count == QAWD_FIRST_RESPONSE_WINDOW_ANSWERS && !next_any_bad;
    next_flags = QAWD_FLAGS_RESET;
    next_flags[QAWD_FLAG_ERR] = next_any_bad;
    next_flags[QAWD_FLAG_EARLY] = fourth && next_first_response_window_count == QAWD_ANSWERS_PER_CYCLE;
    // sequence error when window one count is neither three nor four
    next_flags[QAWD_FLAG_SEQ] = next_first_response_window_count != QAWD_FIRST_RESPONSE_WINDOW_ANSWERS
                                && next_first_response_window_count != QAWD_ANSWERS_PER_CYCLE;
    next_flags[QAWD_FLAG_TIMEOUT] = expire;
  end

  // counters cleared at each cycle start
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      answer_counter <= 2'h0;
      first_response_window_count <= 3'h0;
      any_bad <= 1'b0;
    end else if (restart || end_now) begin
      answer_counter <= 2'h0;
      first_response_window_count <= 3'h0;
      any_bad <= 1'b0;
    end else begin
      answer_counter <= answer_counter + {1'b0, ans_take};
      first_response_window_count <= next_first_response_window_count;
      any_bad <= next_any_bad;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cycle_end <= 1'b0;
      fail_inc <= 1'b0;
      fail_dec <= 1'b0;
      new_question <= 1'b0;
    end else begin
      cycle_end <= end_now;
      fail_inc <= end_now && !pass;
      fail_dec <= pass;
      new_question <= pass;
    end
  end

  // ==========================================
  // Result flags
  // load at cycle end, clear on read; a new result beats the clear
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      {answer_error_flag, early_answer_flag, sequence_error_flag, timeout_flag} <= QAWD_FLAGS_RESET;
    end else if (end_now) begin
      {answer_error_flag, early_answer_flag, sequence_error_flag, timeout_flag} <= next_flags;
    end else if (restart || result_read(reg_rd, reg_addr)) begin
      {answer_error_flag, early_answer_flag, sequence_error_flag, timeout_flag} <= QAWD_FLAGS_RESET;
    end
  end

  // ==========================================
  // Register port
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      answer_mode_select <= QAWD_MODE_RESET;
    end else if (mode_write) begin
      answer_mode_select <= reg_wdata[QAWD_CTRL_MODE];
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        QAWD_ADDR_RESULT: reg_rdata <= {4'h0, flags};
        QAWD_ADDR_COUNT: reg_rdata <= {2'h0, any_bad, first_response_window_count, answer_counter};
        QAWD_ADDR_CTRL: reg_rdata <= {7'h00, answer_mode_select};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================
  // Checks
  property p_pass_dec;
    @(posedge clk) disable iff (!rst_sync_n)
    pass |=> fail_dec && new_question && !fail_inc && flags == 4'h0;
  endproperty
  a_pass_dec: assert property (p_pass_dec) else $error("pass did not decrement");

  property p_fourth_ends;
    @(posedge clk) disable iff (!rst_sync_n)
    fourth |=> cycle_end && answer_counter == 2'h0;
  endproperty
  a_fourth_ends: assert property (p_fourth_ends) else $error("fourth answer did not end cycle");

  property p_fail_same_q;
    @(posedge clk) disable iff (!rst_sync_n)
    end_now && !pass |=> fail_inc && !new_question && !fail_dec;
  endproperty
  a_fail_same_q: assert property (p_fail_same_q) else $error("failure handled wrongly");

  property p_timeout;
    @(posedge clk) disable iff (!rst_sync_n)
    expire |=> timeout_flag && cycle_end && fail_inc;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged");

  property p_seq_only;
    @(posedge clk) disable iff (!rst_sync_n)
    fourth && next_first_response_window_count < 3'h3 && !next_any_bad |=> flags == 4'h2;
  endproperty
  a_seq_only: assert property (p_seq_only) else $error("expected only sequence error");

  property p_sequence_error_flag;
    @(posedge clk) disable iff (!rst_sync_n)
    fourth && next_first_response_window_count < 3'h3 && next_any_bad |=> flags == 4'ha;
  endproperty
  a_sequence_error_flag: assert property (p_sequence_error_flag) else $error("expected answer and sequence error");

  property p_any_bad;
    @(posedge clk) disable iff (!rst_sync_n)
    end_now && (any_bad || (ans_take && !ans_ok)) |=> answer_error_flag;
  endproperty
  a_any_bad: assert property (p_any_bad) else $error("bad answer lost");

  property p_three_idle;
    @(posedge clk) disable iff (!rst_sync_n)
    expire && first_response_window_count == 3'h3 && !any_bad |=> flags == 4'h1;
  endproperty
  a_three_idle: assert property (p_three_idle) else $error("expected only timeout");

  property p_few_idle;
    @(posedge clk) disable iff (!rst_sync_n)
    expire && !any_bad && !ans_take && (first_response_window_count == 3'h1 || first_response_window_count == 3'h2)
      && answer_counter == first_response_window_count[1:0] |=> flags == 4'h3;
  endproperty
  a_few_idle: assert property (p_few_idle) else $error("expected sequence error and timeout");

  property p_read_clear;
    @(posedge clk) disable iff (!rst_sync_n)
    result_read(reg_rd, reg_addr) && !end_now |=> flags == 4'h0 && reg_rdata == {4'h0, $past(flags)};
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("result read wrong");

  property p_single_idle;
    @(posedge clk) disable iff (!rst_sync_n)
    answer_mode_select |=> !cycle_end;
  endproperty
  a_single_idle: assert property (p_single_idle) else $error("evaluated in single mode");

  property p_compare;
    @(posedge clk) disable iff (!rst_sync_n)
    ans_take && !ans_ok && !end_now |=> any_bad;
  endproperty
  a_compare: assert property (p_compare) else $error("mismatch not recorded");

  property p_cnt_zero;
    @(posedge clk) disable iff (!rst_sync_n)
    restart || end_now |=> answer_counter == 2'h0 && first_response_window_count == 3'h0;
  endproperty
  a_cnt_zero: assert property (p_cnt_zero) else $error("counter not cleared");

  property p_restart_quiet;
    @(posedge clk) disable iff (!rst_sync_n)
    restart |=> !cycle_end && !fail_inc && !fail_dec && answer_counter == 2'h0 && flags == 4'h0;
  endproperty
  a_restart_quiet: assert property (p_restart_quiet) else $error("restart left state behind");

  property p_early;
    @(posedge clk) disable iff (!rst_sync_n)
    fourth && next_first_response_window_count == 3'h4
      |=> fail_inc && early_answer_flag && !sequence_error_flag && !timeout_flag;
  endproperty
  a_early: assert property (p_early) else $error("four in window one not failed as early");

  property p_one_verdict;
    @(posedge clk) disable iff (!rst_sync_n)
    cycle_end |-> fail_inc != fail_dec;
  endproperty
  a_one_verdict: assert property (p_one_verdict) else $error("cycle end without single verdict");

  property p_no_stray;
    @(posedge clk) disable iff (!rst_sync_n)
    !cycle_end |-> !fail_inc && !fail_dec && !new_question;
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("verdict pulse outside cycle end");

  property p_rdata_idle;
    @(posedge clk) disable iff (!rst_sync_n)
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

  property p_single_count;
    @(posedge clk) disable iff (!rst_sync_n)
    answer_mode_select |=> answer_counter == 2'h0;
  endproperty
  a_single_count: assert property (p_single_count) else $error("answer counted in single mode");

endmodule

// >>> src/qawd_pkg.sv
package qawd_pkg;
  // ==========================================
  // Register offsets
  localparam logic [3:0] QAWD_ADDR_RESULT = 4'h0;
  localparam logic [3:0] QAWD_ADDR_COUNT = 4'h1;
  localparam logic [3:0] QAWD_ADDR_CTRL = 4'h2;
  localparam logic [3:0] QAWD_ADDR_ANSWER = 4'h3;
  // ==========================================
  // Field positions
  localparam int QAWD_FLAG_TIMEOUT = 0;
  localparam int QAWD_FLAG_SEQ = 1;
  localparam int QAWD_FLAG_EARLY = 2;
  localparam int QAWD_FLAG_ERR = 3;
  localparam int QAWD_CTRL_MODE = 0;
  // ==========================================
  // Reset values and counts
  localparam logic [3:0] QAWD_FLAGS_RESET = 4'h0;
  localparam logic QAWD_MODE_RESET = 1'b0;
  localparam logic [2:0] QAWD_ANSWERS_PER_CYCLE = 3'h4;
  localparam logic [2:0] QAWD_FIRST_RESPONSE_WINDOW_ANSWERS = 3'h3;
  localparam logic [1:0] QAWD_LAST_SLOT = 2'h3;
endpackage

// >>> verif/qawd_mcu_model.sv
`timescale 1ns/1ps
// ==========================================
// Supervised processor on the register port
module qawd_mcu_model
  import qawd_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] expected_answer,
  input wire logic [7:0] reg_rdata,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  // one answer per call
  // Expected byte is taken after the edge so the count has settled from the last answer
  task automatic answer(input logic bad);
    @(posedge clk);
    reg_addr <= QAWD_ADDR_ANSWER;
    reg_wdata <= expected_answer ^ {8{bad}};
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
endmodule

// >>> verif/qawd_answer_eval_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; $display("Error %0t: %h vs %h", $time, a, b); end end
module qawd_answer_eval_bench;
  import qawd_pkg::*;
  logic clk = 0, rst_n = 0, wd_init = 0, first_response_window_active = 0, win2_active = 0, win2_expire = 0;
  logic [7:0] expected_answer, reg_wdata, reg_rdata, d;
  logic [3:0] reg_addr;
  logic reg_wr, reg_rd, cycle_end, fail_inc, fail_dec, new_question, answer_mode_select;
  logic answer_error_flag, early_answer_flag, sequence_error_flag, timeout_flag;
  logic [1:0] answer_counter;
  int err_count = 0, n_compared = 0, cycles = 0;
  int cnt[4] = '{0, 0, 0, 0};
  // Answer depends on question and on the present count
  assign expected_answer = 8'h3c ^ {6'h00, answer_counter};
  qawd_answer_eval qawd_answer_eval_inst (.clk, .rst_n, .wd_init, .first_response_window_active, .win2_active, .win2_expire,
    .expected_answer, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .answer_counter, .cycle_end,
    .fail_inc, .fail_dec, .new_question, .answer_mode_select, .answer_error_flag, .early_answer_flag,
    .sequence_error_flag, .timeout_flag);
  qawd_mcu_model qawd_mcu_model_inst (.clk, .expected_answer, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd);
  initial forever #10 clk = ~clk;
  task automatic results();
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Pulses are tallied so one-cycle outputs are never missed
  always @(posedge clk) begin
    cnt[0] += int'(cycle_end);
    cnt[1] += int'(fail_inc);
    cnt[2] += int'(fail_dec);
    cnt[3] += int'(new_question);
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      results();
    end
  end
  // ==========================================
  // One watchdog cycle; the first b1 and b2 answers of each window are wrong
  task automatic run(input int n1, b1, n2, b2, input logic [3:0] fl, input logic pass);
    int b[4];
    b = cnt;
    @(posedge clk);
    wd_init <= 1'b1;
    first_response_window_active <= 1'b1;
    @(posedge clk);
    wd_init <= 1'b0;
    for (int i = 0; i < n1; i++)
      qawd_mcu_model_inst.answer(i < b1);
    first_response_window_active <= 1'b0;
    win2_active <= 1'b1;
    for (int i = 0; i < n2; i++)
      qawd_mcu_model_inst.answer(i < b2);
    if (n1 + n2 < 4) begin
      @(posedge clk);
      win2_expire <= 1'b1;
      @(posedge clk);
      win2_expire <= 1'b0;
    end
    @(posedge clk);
    win2_active <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(cnt[0] - b[0], 1)
    `CHK(cnt[1] - b[1], int'(!pass))
    `CHK(cnt[2] - b[2], int'(pass))
    `CHK(cnt[3] - b[3], int'(pass))
    `CHK(answer_counter, 2'h0)
    `CHK({answer_error_flag, early_answer_flag, sequence_error_flag, timeout_flag}, fl)
    qawd_mcu_model_inst.rd(QAWD_ADDR_RESULT, d);
    `CHK(d, {4'h0, fl})
    qawd_mcu_model_inst.rd(QAWD_ADDR_RESULT, d);
    `CHK(d, 8'h00)
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    qawd_mcu_model_inst.rd(QAWD_ADDR_CTRL, d);
    `CHK(d, 8'h00)
    qawd_mcu_model_inst.rd(4'hf, d);
    `CHK(d, 8'h00)
    run(3, 0, 1, 0, 4'h0, 1'b1);
    run(1, 0, 3, 0, 4'h2, 1'b0);
    run(2, 0, 2, 1, 4'ha, 1'b0);
    run(3, 0, 1, 1, 4'h8, 1'b0);
    run(3, 0, 0, 0, 4'h1, 1'b0);
    run(2, 0, 0, 0, 4'h3, 1'b0);
    run(1, 0, 0, 0, 4'h3, 1'b0);
    run(0, 0, 0, 0, 4'h3, 1'b0);
    run(2, 1, 1, 0, 4'hb, 1'b0);
    run(4, 1, 0, 0, 4'hc, 1'b0);
    // ==========================================
    // Single-answer mode leaves the evaluation idle
    qawd_mcu_model_inst.wr(QAWD_ADDR_CTRL, 8'h01);
    first_response_window_active <= 1'b1;
    qawd_mcu_model_inst.answer(1'b0);
    @(negedge clk);
    `CHK({answer_mode_select, answer_counter}, 3'h4)
    @(posedge clk);
    first_response_window_active <= 1'b0;
    qawd_mcu_model_inst.wr(QAWD_ADDR_CTRL, 8'h00);
    // Partial cycle: one bad then one good answer, then an init event mid-cycle
    first_response_window_active <= 1'b1;
    qawd_mcu_model_inst.answer(1'b1);
    qawd_mcu_model_inst.answer(1'b0);
    qawd_mcu_model_inst.rd(QAWD_ADDR_COUNT, d);
    `CHK(d, 8'h2a)
    @(posedge clk);
    wd_init <= 1'b1;
    @(posedge clk);
    wd_init <= 1'b0;
    qawd_mcu_model_inst.rd(QAWD_ADDR_COUNT, d);
    `CHK(d, 8'h00)
    first_response_window_active <= 1'b0;
    run(3, 0, 1, 0, 4'h0, 1'b1);
    results();
  end
endmodule
